// File: rtl/recs_pkg.sv
// Purpose: Shared constants and types of the rotational external clock sampler.
// Assumes: Register port with word indices, 32-bit data, 250 MHz reference clock.
// Notes:   Angles are carried in milli-units (for example milli-degrees).

package recs_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned DIV_W    = 16;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL        = 4'h0;
    localparam logic [ADDR_W-1:0] REG_UNIT_SCALE  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CLOCK_SCALE = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CLOCK_SHIFT = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SKIP_COUNT  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CLK_DIV     = 4'h5;
    localparam logic [ADDR_W-1:0] REG_SCALE_RES   = 4'h6;
    localparam logic [ADDR_W-1:0] REG_STATUS      = 4'h7;
    localparam logic [ADDR_W-1:0] REG_REF_OFFSET  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_ANGLE       = 4'h9;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned CTRL_RUN    = 0;
    localparam int unsigned CTRL_EXT    = 1;
    localparam int unsigned CTRL_REF_EN = 2;
    localparam int unsigned CTRL_QUAL   = 3;
    localparam int unsigned CTRL_W      = 4;
    localparam int unsigned STAT_REF    = 0;
    localparam int unsigned STAT_BUSY   = 1;
    localparam int unsigned STAT_OVR    = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [CTRL_W-1:0] CTRL_RST        = 4'h0;
    localparam logic [DATA_W-1:0] UNIT_SCALE_RST  = 32'h0000_0168;
    localparam logic [DATA_W-1:0] CLOCK_SCALE_RST = 32'h0000_05DC;
    localparam logic [DATA_W-1:0] CLOCK_SHIFT_RST = 32'h0000_0000;
    localparam logic [DIV_W-1:0]  SKIP_RST        = 16'h0001;
    localparam logic [DIV_W-1:0]  CLK_DIV_RST     = 16'h0001;
    localparam logic [DATA_W-1:0] SCALE_RES_RST   = 32'h0000_00F0;
    localparam logic [DATA_W-1:0] MILLI           = 32'h0000_03E8;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_PS   = 4000;
    localparam int unsigned EXT_MAX_KSPS    = 2000;
    localparam int unsigned EXT_MIN_GAP_NS  = 1000000 / EXT_MAX_KSPS;
    localparam int unsigned EXT_MIN_GAP_INT =
        (EXT_MIN_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  EXT_MIN_GAP_CYC = 8'(EXT_MIN_GAP_INT);
    localparam logic [5:0]  DIV_LAST_STEP   = 6'h1F;

    typedef enum logic [1:0] {
        RECS_DIV_IDLE = 2'b01,
        RECS_DIV_RUN  = 2'b10
    } recs_div_st_t;

    function automatic logic [DIV_W-1:0] at_least_one(input logic [DIV_W-1:0] v);
        at_least_one = (v == 16'h0000) ? 16'h0001 : v;
    endfunction : at_least_one

endpackage : recs_pkg

// File: rtl/recs_div_if.sv
// Purpose: Carries the external clock divider controls and its events.
// Assumes: One clock domain shared by both ends.
// Notes:   Events are one-cycle pulses.

`timescale 1ns/100ps
`default_nettype none

interface recs_div_if;
    logic                     ext_level;
    logic [recs_pkg::DIV_W-1:0] divide_by;
    logic                     restart;
    logic                     edge_seen;
    logic                     store_req;
    logic                     too_fast;

    modport ctl (output ext_level, divide_by, restart,
                 input  edge_seen, store_req, too_fast);
    modport div (input  ext_level, divide_by, restart,
                 output edge_seen, store_req, too_fast);
endinterface : recs_div_if

`default_nettype wire

// File: rtl/recs_clk_div.sv
// Purpose: Detects external clock edges, divides them and checks their spacing.
// Assumes: The external clock level is synchronous to ref_clk.
// Notes:   A divide value of zero acts as one.

`timescale 1ns/100ps
`default_nettype none

module recs_clk_div (
    input  wire logic ref_clk,
    input  wire logic resetn,
    recs_div_if.div   dif
);
    import recs_pkg::*;

    typedef struct packed {
        logic             prev;
        logic [DIV_W-1:0] cnt;
        logic [7:0]       gap;
        logic             edge_seen;
        logic             store_req;
        logic             too_fast;
    } recs_cd_state_t;

    recs_cd_state_t s_reg;
    recs_cd_state_t s_next;
    logic           rise;

    assign rise          = dif.ext_level & ~s_reg.prev;
    assign dif.edge_seen = s_reg.edge_seen;
    assign dif.store_req = s_reg.store_req;
    assign dif.too_fast  = s_reg.too_fast;

    always_comb begin
        s_next           = s_reg;
        s_next.prev      = dif.ext_level;
        s_next.edge_seen = 1'b0;
        s_next.store_req = 1'b0;
        s_next.too_fast  = 1'b0;
        if (s_reg.gap != EXT_MIN_GAP_CYC) begin
            s_next.gap = s_reg.gap + 8'h01;
        end
        if (dif.restart) begin
            s_next.cnt = '0;
            s_next.gap = EXT_MIN_GAP_CYC;
        end else if (rise) begin
            s_next.edge_seen = 1'b1;
            s_next.gap       = 8'h00;
            // Edges faster than the mainframe limit cost samples downstream.
            s_next.too_fast  = (s_reg.gap < EXT_MIN_GAP_CYC);
            // One store request per N edges, never more than one per edge.
            if (s_reg.cnt + 16'h0001 >= at_least_one(dif.divide_by)) begin
                s_next.cnt       = '0;
                s_next.store_req = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '{prev: 1'b0, cnt: '0, gap: EXT_MIN_GAP_CYC,
                       edge_seen: 1'b0, store_req: 1'b0, too_fast: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_req_follows_edge: assert property (dif.store_req |-> dif.edge_seen)
        else $error("store request without an external edge");
    chk_div_count_bound: assert property (
        $stable(dif.divide_by) && $past(s_reg.cnt < at_least_one(dif.divide_by))
        |-> s_reg.cnt < at_least_one(dif.divide_by))
        else $error("divider count reached the divide value");

endmodule : recs_clk_div

`default_nettype wire

// File: rtl/recs_sampler.sv
// Purpose: Stores converter samples against an external rotational clock with angle tags.
// Assumes: All pins synchronous to ref_clk; converter delivers adc_valid at its top rate.
// Notes:   Angles are in milli-units; the reference re-bases later angles.
//
// How it works
// - Setting the external mode bit makes the external clock, not the converter rate, pace storage.
// - The angle step per pulse is the unit scaling times one thousand divided by the clock scaling.
// - The clock shift is the angle the reference pulse is given.
// - The reference offset is kept readable so earlier samples can be counted back from it.
// - With reference enabled, rising edges of the trigger input establish the zero angle.
// - The Nth accepted reference pulse after start becomes the zero, earlier ones are ignored.
// - In a 720-unit cycle the qualifier picks which of the two pulses per cycle is zero.
// - With the qualifier on, the alarm level is ANDed with the trigger input.
// - With the qualifier on, reference detection is open only while the alarm stands and closes again when it drops.
// - Every Nth external edge requests one stored sample, with N of one by default.
// - At most one sample is stored per external edge.
// - After a request the next converter sample is stored, giving up to one sample of jitter.
// - Edges are accepted below 2 MS/s and edges 500 ns or less apart are flagged as overrun.

`timescale 1ns/100ps
`default_nettype none

module recs_sampler (
    input  wire logic                            ref_clk,
    input  wire logic                            resetn,
    input  wire logic [recs_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [recs_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [recs_pkg::DATA_W-1:0]     reg_rdata,
    input  wire logic                            ext_clk_in,
    input  wire logic                            ext_trig_in,
    input  wire logic                            alarm_in,
    input  wire logic                            adc_valid,
    input  wire logic [recs_pkg::SAMPLE_W-1:0]   adc_data,
    output logic                                 store_valid,
    output logic      [recs_pkg::SAMPLE_W-1:0]   store_data,
    output logic      [recs_pkg::DATA_W-1:0]     store_angle,
    output logic                                 ref_found
);
    import recs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [CTRL_W-1:0]   ctrl;
        logic [DATA_W-1:0]   unit_scale;
        logic [DATA_W-1:0]   clock_scale;
        logic [DATA_W-1:0]   clock_shift;
        logic [DIV_W-1:0]    skip_cfg;
        logic [DIV_W-1:0]    clk_div;
        logic [DATA_W-1:0]   scale_res;
        recs_div_st_t        div_st;
        logic [DATA_W-1:0]   quo;
        logic [DATA_W:0]     rem;
        logic [5:0]          step;
        logic                run_prev;
        logic                trig_prev;
        logic                ref_seen;
        logic [DIV_W-1:0]    skip_seen;
        logic [DATA_W-1:0]   angle_raw;
        logic [DATA_W-1:0]   ref_offset;
        logic                pending;
        logic                overrun;
        logic                store_valid;
        logic [SAMPLE_W-1:0] store_data;
        logic [DATA_W-1:0]   store_angle;
        logic [DATA_W-1:0]   rdata;
    } recs_state_t;

    recs_state_t s_reg;
    recs_state_t s_next;
    logic        restart;
    logic        run_now;
    logic        trig_rise;
    logic        qual_pulse;

    recs_div_if div_if ();

    recs_clk_div u_clk_div (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .dif     (div_if.div)
    );

    assign restart          = s_reg.ctrl[CTRL_RUN] & ~s_reg.run_prev;
    assign run_now          = s_reg.ctrl[CTRL_RUN] & s_reg.run_prev;
    assign trig_rise        = ext_trig_in & ~s_reg.trig_prev;
    // With the qualifier bit set, the alarm gates the trigger so only the pulse inside the alarm window counts.
    assign qual_pulse       = trig_rise & (~s_reg.ctrl[CTRL_QUAL] | alarm_in);
    assign div_if.ext_level = ext_clk_in;
    assign div_if.divide_by = s_reg.clk_div;
    assign div_if.restart   = restart;

    assign reg_rdata   = s_reg.rdata;
    assign store_valid = s_reg.store_valid;
    assign store_data  = s_reg.store_data;
    assign store_angle = s_reg.store_angle;
    assign ref_found   = s_reg.ref_seen;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [DATA_W:0] rem_sh;
        rem_sh             = '0;
        s_next             = s_reg;
        s_next.store_valid = 1'b0;
        s_next.rdata       = '0;
        s_next.run_prev    = s_reg.ctrl[CTRL_RUN];
        s_next.trig_prev   = ext_trig_in;

        // Restoring division, one quotient bit per cycle.
        // Bit-serial work keeps the block small; software polls the busy bit until it clears.
        if (s_reg.div_st == RECS_DIV_RUN) begin
            rem_sh     = {s_reg.rem[DATA_W-1:0], s_reg.quo[DATA_W-1]};
            s_next.quo = {s_reg.quo[DATA_W-2:0], 1'b0};
            if (rem_sh >= {1'b0, s_reg.clock_scale}) begin
                rem_sh        = rem_sh - {1'b0, s_reg.clock_scale};
                s_next.quo[0] = 1'b1;
            end
            s_next.rem  = rem_sh;
            s_next.step = s_reg.step + 6'h01;
            if (s_reg.step == DIV_LAST_STEP) begin
                s_next.scale_res = s_next.quo;
                s_next.div_st    = RECS_DIV_IDLE;
            end
        end

        if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL:        s_next.ctrl        = reg_wdata[CTRL_W-1:0];
                REG_UNIT_SCALE:  s_next.unit_scale  = reg_wdata;
                REG_CLOCK_SCALE: s_next.clock_scale = reg_wdata;
                REG_CLOCK_SHIFT: s_next.clock_shift = reg_wdata;
                REG_SKIP_COUNT:  s_next.skip_cfg    = reg_wdata[DIV_W-1:0];
                REG_CLK_DIV:     s_next.clk_div     = reg_wdata[DIV_W-1:0];
                REG_STATUS: begin
                    if (reg_wdata[STAT_OVR]) begin
                        s_next.overrun = 1'b0;
                    end
                end
                default: ;
            endcase
            if (reg_addr == REG_UNIT_SCALE || reg_addr == REG_CLOCK_SCALE) begin
                s_next.div_st = RECS_DIV_RUN;
                s_next.step   = 6'h00;
                s_next.rem    = '0;
                s_next.quo    = (reg_addr == REG_UNIT_SCALE)
                                ? 32'(reg_wdata * MILLI) : 32'(s_reg.unit_scale * MILLI);
            end
        end

        if (restart) begin
            // Every recording starts from angle zero with no reference.
            s_next.angle_raw  = '0;
            s_next.ref_seen   = 1'b0;
            s_next.skip_seen  = '0;
            s_next.ref_offset = '0;
            s_next.pending    = 1'b0;
        end else if (run_now) begin
            if (div_if.edge_seen) begin
                s_next.angle_raw = s_reg.angle_raw + s_reg.scale_res;
            end
            if (s_reg.ctrl[CTRL_REF_EN] && !s_reg.ref_seen && qual_pulse) begin
                s_next.skip_seen = s_reg.skip_seen + 16'h0001;
                if (s_reg.skip_seen + 16'h0001 >= at_least_one(s_reg.skip_cfg)) begin
                    s_next.ref_seen   = 1'b1;
                    // Raw angle minus offset equals the shift at the reference.
                    s_next.ref_offset = s_reg.angle_raw - s_reg.clock_shift;
                end
            end
            if (s_reg.ctrl[CTRL_EXT]) begin
                // Only a sample taken after the request is stored.
                if (adc_valid && s_reg.pending) begin
                    s_next.store_valid = 1'b1;
                    s_next.pending     = 1'b0;
                end
                if (div_if.store_req) begin
                    // A request still waiting is lost; the source ran too fast.
                    if (s_reg.pending && !adc_valid) begin
                        s_next.overrun = 1'b1;
                    end
                    s_next.pending = 1'b1;
                end
            end else if (adc_valid) begin
                s_next.store_valid = 1'b1;
            end
            if (div_if.too_fast) begin
                s_next.overrun = 1'b1;
            end
        end

        if (s_next.store_valid) begin
            s_next.store_data  = adc_data;
            s_next.store_angle = s_reg.ref_seen ? s_reg.angle_raw - s_reg.ref_offset
                                                : s_reg.angle_raw;
        end

        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:        s_next.rdata = {28'h0000000, s_reg.ctrl};
                REG_UNIT_SCALE:  s_next.rdata = s_reg.unit_scale;
                REG_CLOCK_SCALE: s_next.rdata = s_reg.clock_scale;
                REG_CLOCK_SHIFT: s_next.rdata = s_reg.clock_shift;
                REG_SKIP_COUNT:  s_next.rdata = {16'h0000, s_reg.skip_cfg};
                REG_CLK_DIV:     s_next.rdata = {16'h0000, s_reg.clk_div};
                REG_SCALE_RES:   s_next.rdata = s_reg.scale_res;
                REG_STATUS:      s_next.rdata = {29'h00000000, s_reg.overrun,
                                                 s_reg.div_st == RECS_DIV_RUN, s_reg.ref_seen};
                REG_REF_OFFSET:  s_next.rdata = s_reg.ref_offset;
                REG_ANGLE:       s_next.rdata = s_reg.angle_raw;
                default:         s_next.rdata = '0;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '{ctrl: CTRL_RST, unit_scale: UNIT_SCALE_RST,
                       clock_scale: CLOCK_SCALE_RST, clock_shift: CLOCK_SHIFT_RST,
                       skip_cfg: SKIP_RST, clk_div: CLK_DIV_RST,
                       scale_res: SCALE_RES_RST, div_st: RECS_DIV_IDLE,
                       quo: '0, rem: '0, step: '0, run_prev: 1'b0, trig_prev: 1'b0,
                       ref_seen: 1'b0, skip_seen: '0, angle_raw: '0, ref_offset: '0,
                       pending: 1'b0, overrun: 1'b0, store_valid: 1'b0,
                       store_data: '0, store_angle: '0, rdata: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_store_needs_run: assert property (store_valid |-> $past(run_now))
        else $error("sample stored while not recording");
    chk_ext_store_pending: assert property (
        store_valid && $past(s_reg.ctrl[CTRL_EXT]) |-> $past(s_reg.pending) && $past(adc_valid))
        else $error("external sample stored without a pending request");
    chk_scale_result: assert property (
        $past(s_reg.div_st == RECS_DIV_RUN && s_reg.step == DIV_LAST_STEP && !reg_wr)
        && s_reg.clock_scale != 32'h0000_0000
        |-> s_reg.scale_res == 32'(s_reg.unit_scale * MILLI) / s_reg.clock_scale)
        else $error("scale result is not unit over clock scaling");
    chk_ref_offset_val: assert property (
        $rose(ref_found) |-> s_reg.ref_offset == $past(s_reg.angle_raw) - $past(s_reg.clock_shift))
        else $error("reference offset does not place the shift at the reference");
    chk_ref_needs_enable: assert property ($rose(ref_found) |-> $past(s_reg.ctrl[CTRL_REF_EN]))
        else $error("reference taken while detection disabled");
    chk_ref_qualified: assert property (
        $rose(ref_found) && $past(s_reg.ctrl[CTRL_QUAL]) |-> $past(alarm_in) && $past(trig_rise))
        else $error("qualified reference without alarm and trigger");
    chk_ref_skip_count: assert property (
        $rose(ref_found) |-> $past(s_reg.skip_seen) + 16'h0001 == at_least_one($past(s_reg.skip_cfg)))
        else $error("reference not tied to the configured occurrence");
    chk_angle_step: assert property (
        run_now && div_if.edge_seen && !restart
        |=> s_reg.angle_raw == $past(s_reg.angle_raw) + $past(s_reg.scale_res))
        else $error("angle did not advance by one step on an edge");
    chk_angle_rebased: assert property (
        store_valid && $past(s_reg.ref_seen)
        |-> store_angle == $past(s_reg.angle_raw) - $past(s_reg.ref_offset))
        else $error("stored angle not taken relative to the reference");
    // Overrun is sticky and a set beats a clear in the same cycle.
    // This way a lost sample is never hidden by a badly timed clear write.
    chk_fast_edge_flag: assert property (
        run_now && div_if.too_fast |=> s_reg.overrun)
        else $error("fast edge not flagged");
    chk_lost_req_flag: assert property (
        run_now && s_reg.ctrl[CTRL_EXT] && div_if.store_req && s_reg.pending && !adc_valid
        |=> s_reg.overrun)
        else $error("lost request not flagged");
    chk_overrun_sticky: assert property (
        s_reg.overrun && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_OVR])
        |=> s_reg.overrun)
        else $error("overrun cleared without a clear write");
    chk_restart_clears: assert property (
        restart |=> s_reg.angle_raw == '0 && !ref_found && !s_reg.pending)
        else $error("recording did not start clean");
    chk_ref_kept: assert property (ref_found && !restart |=> ref_found)
        else $error("reference dropped");
    chk_ref_closed_low: assert property (
        s_reg.ctrl[CTRL_QUAL] && !alarm_in |=> $stable(s_reg.skip_seen) || $past(restart))
        else $error("reference counted without alarm");
    chk_int_store_each: assert property (
        run_now && !s_reg.ctrl[CTRL_EXT] && adc_valid
        |=> store_valid && store_data == $past(adc_data))
        else $error("internal sample not stored");
    chk_store_held: assert property (
        !store_valid |-> $stable(store_data) && $stable(store_angle))
        else $error("stored sample changed without a store");

endmodule : recs_sampler

`default_nettype wire

// File: test/recs_encoder_model.sv
// Purpose: Encoder and reference pulse source facing the sampler.
// Assumes: Levels change by non-blocking assignment just after rising ref_clk edges.
// Notes:   Each external clock pulse is followed by a long quiet gap.

`timescale 1ns/100ps
`default_nettype none

module recs_encoder_model (
    input  wire logic ref_clk,
    output var  logic ext_clk,
    output var  logic ext_trig
);
    initial begin
        ext_clk  = 1'b0;
        ext_trig = 1'b0;
    end

    // A 131 cycle period keeps the source just below the 2 MS/s limit.
    task automatic spin(input int n);
        repeat (n) begin
            @(posedge ref_clk) ext_clk <= 1'b1;
            repeat (2) @(posedge ref_clk);
            ext_clk <= 1'b0;
            repeat (128) @(posedge ref_clk);
        end
    endtask : spin

    task automatic ref_pulse();
        @(posedge ref_clk) ext_trig <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ext_trig <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : ref_pulse
endmodule : recs_encoder_model

`default_nettype wire

// File: test/rotational_external_clock_sampler_bench.sv
// Purpose: Self-checking bench for the rotational external clock sampler.
// Assumes: The converter strobes every other cycle; the encoder model paces edges.
// Notes:   Angles are compared in milli-units.

`timescale 1ns/100ps
`default_nettype none

module rotational_external_clock_sampler_bench;
    import recs_pkg::*;
    logic                ref_clk, resetn, reg_wr, reg_rd, adc_valid, alarm_in;
    logic                ext_clk_in, ext_trig_in, store_valid, ref_found;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata, reg_rdata, store_angle, last_angle, v;
    logic [SAMPLE_W-1:0] adc_data, store_data, adc_prev;
    int                  n_errors, samples_checked, n_store;

    recs_sampler u_recs_sampler (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clk_in(ext_clk_in), .ext_trig_in(ext_trig_in), .alarm_in(alarm_in),
        .adc_valid(adc_valid), .adc_data(adc_data), .store_valid(store_valid),
        .store_data(store_data), .store_angle(store_angle), .ref_found(ref_found));
    recs_encoder_model u_recs_encoder_model (.ref_clk(ref_clk), .ext_clk(ext_clk_in),
        .ext_trig(ext_trig_in));

    always #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (store_valid === 1'b1) begin
            n_store++;
            last_angle = store_angle;
            check({16'h0000, store_data}, {16'h0000, adc_prev});
        end
        adc_prev   = adc_data;
        adc_valid <= ~adc_valid;
        adc_data  <= adc_data + 16'h0001;
    end

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_registers();
        rd(REG_SCALE_RES);
        check(v, 32'h0000_00F0);
        rd(REG_CLK_DIV);
        check(v, 32'h0000_0001);
        rd(4'hF);
        check(v, 32'h0000_0000);
        wr(REG_UNIT_SCALE, 32'h0000_02D0);
        repeat (40) @(posedge ref_clk);
        rd(REG_SCALE_RES);
        check(v, 32'h0000_01E0);
        wr(REG_UNIT_SCALE, 32'h0000_0168);
        repeat (40) @(posedge ref_clk);
        wr(REG_CTRL, 32'h0000_0001);
        repeat (10) @(posedge ref_clk);
        wr(REG_CTRL, 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
        check(32'(n_store), 32'h0000_0006);
    endtask : t_registers

    task automatic t_divider();
        wr(REG_CLK_DIV, 32'h0000_0003);
        wr(REG_CTRL, 32'h0000_0003);
        n_store = 0;
        repeat (20) @(posedge ref_clk);
        check(32'(n_store), 32'h0000_0000);
        u_recs_encoder_model.spin(6);
        check(32'(n_store), 32'h0000_0002);
        check(last_angle, 32'h0000_05A0);
        rd(REG_STATUS);
        check(v, 32'h0000_0000);
    endtask : t_divider

    task automatic t_reference();
        wr(REG_CTRL, 32'h0000_0000);
        wr(REG_CLK_DIV, 32'h0000_0001);
        wr(REG_SKIP_COUNT, 32'h0000_0002);
        wr(REG_CLOCK_SHIFT, 32'h0000_8D04);
        wr(REG_CTRL, 32'h0000_000F);
        u_recs_encoder_model.spin(1);
        u_recs_encoder_model.ref_pulse();
        u_recs_encoder_model.spin(1);
        @(posedge ref_clk) alarm_in <= 1'b1;
        u_recs_encoder_model.ref_pulse();
        check({31'h0, ref_found}, 32'h0000_0000);
        u_recs_encoder_model.spin(1);
        u_recs_encoder_model.ref_pulse();
        @(posedge ref_clk) alarm_in <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, ref_found}, 32'h0000_0001);
        rd(REG_REF_OFFSET);
        check(v, 32'hFFFF_75CC);
        u_recs_encoder_model.spin(1);
        check(last_angle, 32'h0000_8DF4);
    endtask : t_reference

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    initial begin
        {ref_clk, resetn, reg_wr, reg_rd, adc_valid, alarm_in} = 6'h00;
        {reg_addr, reg_wdata, adc_data, adc_prev, last_angle} = '0;
        {n_errors, samples_checked, n_store} = '0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        t_registers();
        t_divider();
        t_reference();
        report_and_stop();
    end

    // The tests need under 3000 cycles, so this limit only trips on a hang.
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
endmodule : rotational_external_clock_sampler_bench

`default_nettype wire
